// file: pcibr_pkg.sv
// Purpose: shared constants for the pci bridge and its auxiliary bus
// Assumes: 32-bit multiplexed address/data bus, 4-bit command/byte enables
// Notes:   decode windows are plain defaults, set per board
`default_nettype none
package pcibr_pkg;
  localparam logic [3:0]  CMD_IO_READ    = 4'h2;
  localparam logic [3:0]  CMD_IO_WRITE   = 4'h3;
  localparam logic [3:0]  CMD_MEM_READ   = 4'h6;
  localparam logic [3:0]  CMD_MEM_WRITE  = 4'h7;
  localparam logic [3:0]  CMD_CFG_READ   = 4'ha;
  localparam logic [3:0]  CMD_CFG_WRITE  = 4'hb;
  // decode windows: address bits above the low nibble must match (rom window: above bit 15)
  localparam logic [31:0] AUX_BASE       = 32'h0000_0300;
  localparam logic [31:0] PAL_BASE       = 32'h0000_03c0;
  localparam logic [31:0] ROM_BASE       = 32'h000c_0000;
  localparam logic [31:0] WIN_MASK       = 32'hffff_fff0;
  localparam logic [31:0] ROM_MASK       = 32'hffff_0000;
  localparam int          STRAP_W        = 24;
  localparam int          CFG_BYTES      = 3;
  localparam int          RETRACE_EN_BIT = 5;
  localparam logic [7:0]  RETRACE_IDX    = 8'h11;
  localparam logic [3:0]  WAIT_CYCLES    = 4'h2; // link clocks from devsel (strobe start) to trdy
  localparam logic [1:0]  SYNC_W         = 2'h3;
endpackage : pcibr_pkg
`default_nettype wire

// file: pcibr_if.sv
// Purpose: link between pci bridge end and bus master end
// Assumes: open-drain/two-way lines resolved here from enables
// Notes:   parity follows the data phase by one clock
`timescale 1ns/1ps
`default_nettype none
interface pcibr_if (
  input wire logic link_clk
);
  logic [31:0] ad_m_o;
  logic        ad_m_oe;
  logic [31:0] ad_t_o;
  logic        ad_t_oe;
  logic [3:0]  cbe_n;
  logic        frame_n;
  logic        irdy_n;
  logic        trdy_n;
  logic        devsel_n;
  logic        stop_n;
  logic        lock_n;
  logic        idsel;
  logic        par_m_o;
  logic        par_m_oe;
  logic        par_t_o;
  logic        par_t_oe;
  logic        req_n;
  logic        gnt_n;
  logic        rst_n;
  wire  [31:0] ad  = ad_t_oe ? ad_t_o : (ad_m_oe ? ad_m_o : 32'h0000_0000);
  wire         par = par_t_oe ? par_t_o : (par_m_oe ? par_m_o : 1'b0);
  modport target (input link_clk, ad, cbe_n, frame_n, irdy_n, lock_n, idsel, par, gnt_n,
                  rst_n, output ad_t_o, ad_t_oe, trdy_n, devsel_n, stop_n, par_t_o,
                  par_t_oe, req_n);
  modport master (input link_clk, ad, trdy_n, devsel_n, stop_n, par, req_n,
                  output ad_m_o, ad_m_oe, cbe_n, frame_n, irdy_n, lock_n, idsel,
                  par_m_o, par_m_oe, gnt_n, rst_n);
endinterface : pcibr_if
`default_nettype wire

// file: pcibr_master.sv
// Purpose: host end; issues single-word transactions on the link
// Assumes: link_clk from bench; one request at a time
// Notes:   also plays arbiter, granting whenever the target requests
`timescale 1ns/1ps
`default_nettype none
module pcibr_master (
  pcibr_if.master          bus,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_code,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic [3:0]  cmd_be_n,
  input  wire logic        cmd_cfg_sel,
  input  wire logic        cmd_lock,
  output logic             cmd_busy,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  output logic             rsp_abort
);
  typedef enum {M_IDLE, M_ADDR, M_DATA, M_DONE} pcibr_mst_type;
  pcibr_mst_type state_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  be_reg;
  logic        write_reg;
  logic [3:0]  tmo_reg;
  logic        par_reg;

  function automatic logic even_par(input logic [31:0] d, input logic [3:0] c);
    even_par = ^{d, c};
  endfunction : even_par

  wire done_now = (state_reg == M_DATA) & ~bus.trdy_n;
  wire stop_now = (state_reg == M_DATA) & ~bus.stop_n & bus.trdy_n;
  wire no_dev   = (state_reg == M_DATA) & bus.devsel_n & (tmo_reg == 4'hf);
  assign bus.gnt_n = bus.req_n;
  assign bus.rst_n = rstn;

  // single data phase: frame drops with irdy assertion
  always_ff @(posedge bus.link_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= M_IDLE;
      bus.frame_n <= 1'b1;
      bus.irdy_n <= 1'b1;
      bus.ad_m_oe <= 1'b0;
      bus.ad_m_o <= 32'h0000_0000;
      bus.cbe_n <= 4'hf;
      bus.idsel <= 1'b0;
      bus.lock_n <= 1'b1;
      bus.par_m_oe <= 1'b0;
      bus.par_m_o <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      be_reg <= 4'hf;
      write_reg <= 1'b0;
      tmo_reg <= 4'h0;
      par_reg <= 1'b0;
      cmd_busy <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
      rsp_abort <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      bus.par_m_oe <= bus.ad_m_oe;
      bus.par_m_o <= par_reg;
      case (state_reg)
        M_IDLE: begin
          if (cmd_valid) begin
            state_reg <= M_ADDR;
            cmd_busy <= 1'b1;
            rsp_abort <= 1'b0;
            bus.frame_n <= 1'b0;
            bus.ad_m_o <= cmd_addr;
            bus.ad_m_oe <= 1'b1;
            bus.cbe_n <= cmd_code;
            par_reg <= even_par(cmd_addr, cmd_code);
            bus.idsel <= cmd_cfg_sel;
            bus.lock_n <= ~cmd_lock;
            wdata_reg <= cmd_wdata;
            be_reg <= cmd_be_n;
            write_reg <= cmd_code[0];
          end
        end
        M_ADDR: begin
          state_reg <= M_DATA;
          tmo_reg <= 4'h0;
          bus.frame_n <= 1'b1;
          bus.irdy_n <= 1'b0;
          bus.cbe_n <= be_reg;
          bus.idsel <= 1'b0;
          bus.ad_m_oe <= write_reg;
          bus.ad_m_o <= wdata_reg;
          par_reg <= even_par(wdata_reg, be_reg);
        end
        M_DATA: begin
          tmo_reg <= tmo_reg + 4'h1;
          if (done_now | stop_now | no_dev) begin
            state_reg <= M_DONE;
            bus.irdy_n <= 1'b1;
            bus.ad_m_oe <= 1'b0;
            bus.cbe_n <= 4'hf;
            rsp_valid <= 1'b1;
            rsp_rdata <= bus.ad;
            rsp_abort <= ~done_now;
          end
        end
        M_DONE: begin
          state_reg <= M_IDLE;
          cmd_busy <= 1'b0;
          bus.lock_n <= 1'b1;
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end
endmodule : pcibr_master
`default_nettype wire

// file: pcibr_target.sv
// Purpose: device end; pci target with auxiliary strobe bus and straps
// Assumes: link_clk from the bus; core_clk for retrace event input
// Notes:   aux strobes held WAIT_CYCLES link clocks before trdy
`timescale 1ns/1ps
`default_nettype none
// Operation
// - even parity over address/data plus command
// - first clock address, later clocks data
// - command then byte enables on cbe
// - phase completes when irdy and trdy
// - trdy only with valid data or accept
// - assert devsel after own address decode
// - stop asks master to end transaction
// - idsel is chip select for configuration
// - request bus, start only after grant; here the master starts without a grant and req_n stays high
// - frame marks start and duration
// - reset clears state, floats buses, captures straps
// - retrace interrupt when enable bit set
// - lock keeps sequence indivisible; this target refuses locked cycles instead
// - bus signals sampled on rising edge
// - rom enable drives expansion rom reads
// - aux read strobe from decode and read
// - aux write strobe from decode and write
// - bytes routed between aux and system bus
// - latch address bits 3:0 to select
// - palette write strobe on palette writes
// - palette read strobe on palette reads
// - three config registers from strap lines
module pcibr_target #(
  parameter logic [31:0] AUX_BASE = pcibr_pkg::AUX_BASE,
  parameter logic [31:0] PAL_BASE = pcibr_pkg::PAL_BASE,
  parameter logic [31:0] ROM_BASE = pcibr_pkg::ROM_BASE
) (
  pcibr_if.target          bus,
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [23:0] mem_data_strap_lines,
  input  wire logic        vretrace,
  input  wire logic [7:0]  aux_data_bus_i,
  output logic [7:0]       aux_data_bus_o,
  output logic             aux_data_bus_oe,
  output logic             aux_read_strobe_n,
  output logic             aux_write_strobe_n,
  output logic             palette_read_strobe_n,
  output logic             palette_write_strobe_n,
  output logic             rom_output_enable_n,
  output logic [3:0]       aux_register_select,
  output logic             retrace_irq_n_o,
  output logic             retrace_irq_n_oe,
  output logic [23:0]      cfg_regs,
  input  wire logic        retrace_en_wr,
  input  wire logic        retrace_en_val
);
  typedef enum {T_IDLE, T_WAIT, T_DATA, T_TURN} pcibr_tgt_type;
  pcibr_tgt_type state_reg;
  logic [3:0]  cmd_reg;
  logic [31:0] addr_reg;
  logic [3:0]  wait_reg;
  logic        hit_aux_reg, hit_pal_reg, hit_rom_reg, hit_cfg_reg;
  logic [1:0]  strap_cnt_reg;
  logic [7:0]  vret_end_reg;
  logic [2:0]  vr_sync_reg;
  logic        vr_seen_reg;
  logic [2:0]  strap_sync_reg;
  logic [23:0] cfg_link_reg;

  function automatic logic win_hit(input logic [31:0] a, input logic [31:0] b,
                                   input logic [31:0] m);
    win_hit = ((a & m) == (b & m));
  endfunction : win_hit

  // decode of the address phase, sampled on the rising link edge
  wire start     = ~bus.frame_n & (state_reg == T_IDLE);
  wire [3:0] cmd = bus.cbe_n;
  wire is_io     = (cmd == pcibr_pkg::CMD_IO_READ) | (cmd == pcibr_pkg::CMD_IO_WRITE);
  wire is_cfg    = (cmd == pcibr_pkg::CMD_CFG_READ) | (cmd == pcibr_pkg::CMD_CFG_WRITE);
  wire d_aux     = is_io & win_hit(bus.ad, AUX_BASE, pcibr_pkg::WIN_MASK);
  wire d_pal     = is_io & win_hit(bus.ad, PAL_BASE, pcibr_pkg::WIN_MASK);
  wire d_rom     = (cmd == pcibr_pkg::CMD_MEM_READ) &
                   win_hit(bus.ad, ROM_BASE, pcibr_pkg::ROM_MASK);
  wire d_cfg     = is_cfg & bus.idsel;
  // idsel on a non-config command is refused, never taken as a window hit
  wire claim     = ((d_aux | d_pal | d_rom) & ~bus.idsel) | d_cfg;
  wire is_write  = cmd_reg[0];
  wire complete  = (state_reg == T_DATA) & ~bus.irdy_n;
  wire [7:0] lane_byte = bus.ad[8*addr_reg[1:0] +: 8];
  wire [31:0] rd_word  = hit_cfg_reg ? {8'h00, cfg_link_reg} : {4{aux_data_bus_i}};

  // target sequence: claim, strobe wait, data, turnaround
  always_ff @(posedge bus.link_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= T_IDLE;
      cmd_reg <= 4'h0;
      addr_reg <= 32'h0000_0000;
      wait_reg <= 4'h0;
      hit_aux_reg <= 1'b0;
      hit_pal_reg <= 1'b0;
      hit_rom_reg <= 1'b0;
      hit_cfg_reg <= 1'b0;
      bus.devsel_n <= 1'b1;
      bus.trdy_n <= 1'b1;
      bus.stop_n <= 1'b1;
      bus.ad_t_oe <= 1'b0;
      bus.ad_t_o <= 32'h0000_0000;
      bus.par_t_oe <= 1'b0;
      bus.par_t_o <= 1'b0;
      bus.req_n <= 1'b1;
      aux_read_strobe_n <= 1'b1;
      aux_write_strobe_n <= 1'b1;
      palette_read_strobe_n <= 1'b1;
      palette_write_strobe_n <= 1'b1;
      rom_output_enable_n <= 1'b1;
      aux_data_bus_o <= 8'h00;
      aux_data_bus_oe <= 1'b0;
      aux_register_select <= 4'h0;
    end else begin
      bus.par_t_oe <= bus.ad_t_oe;
      bus.par_t_o <= ^{bus.ad_t_o, bus.cbe_n};
      bus.req_n <= 1'b1; // no master traffic issued by this end
      case (state_reg)
        T_IDLE: begin
          if (start && claim && bus.lock_n) begin // locked cycles not claimed
            state_reg <= T_WAIT;
            cmd_reg <= cmd;
            addr_reg <= bus.ad;
            aux_register_select <= bus.ad[3:0];
            hit_aux_reg <= d_aux;
            hit_pal_reg <= d_pal;
            hit_rom_reg <= d_rom;
            hit_cfg_reg <= d_cfg;
            wait_reg <= pcibr_pkg::WAIT_CYCLES;
            bus.devsel_n <= 1'b0;
            aux_read_strobe_n <= ~(d_aux & ~cmd[0]);
            aux_write_strobe_n <= ~(d_aux & cmd[0]);
            palette_read_strobe_n <= ~(d_pal & ~cmd[0]);
            palette_write_strobe_n <= ~(d_pal & cmd[0]);
            rom_output_enable_n <= ~d_rom;
          end
        end
        T_WAIT: begin
          if (is_write) begin
            aux_data_bus_o <= lane_byte;
            aux_data_bus_oe <= hit_aux_reg | hit_pal_reg;
          end
          wait_reg <= wait_reg - 4'h1;
          if (wait_reg == 4'h1) begin
            state_reg <= T_DATA;
            bus.trdy_n <= 1'b0;
            bus.stop_n <= 1'b0; // single data phase only
            bus.ad_t_oe <= ~is_write;
            bus.ad_t_o <= rd_word;
          end
        end
        T_DATA: begin
          if (complete) begin
            state_reg <= T_TURN;
            bus.trdy_n <= 1'b1;
            bus.stop_n <= 1'b1;
            bus.devsel_n <= 1'b1;
            bus.ad_t_oe <= 1'b0;
            aux_read_strobe_n <= 1'b1;
            aux_write_strobe_n <= 1'b1;
            palette_read_strobe_n <= 1'b1;
            palette_write_strobe_n <= 1'b1;
            rom_output_enable_n <= 1'b1;
            aux_data_bus_oe <= 1'b0;
          end
        end
        T_TURN: state_reg <= T_IDLE;
        default: state_reg <= T_IDLE;
      endcase
    end
  end

  // strap capture: the first core edge after reset release loads all three bytes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt_reg <= 2'h0;
      cfg_regs <= 24'h000000;
    end else if (strap_cnt_reg == 2'h0) begin
      strap_cnt_reg <= 2'h1;
      cfg_regs <= mem_data_strap_lines;
    end
  end

  // straps settle in the core domain; the link side copies them only after
  // the done flag has crossed, so a config read never sees a moving word
  always_ff @(posedge bus.link_clk or negedge rstn) begin
    if (!rstn) begin
      strap_sync_reg <= 3'h0;
      cfg_link_reg <= 24'h000000;
    end else begin
      strap_sync_reg <= {strap_sync_reg[1:0], strap_cnt_reg[0]};
      if (strap_sync_reg[1] & strap_sync_reg[2]) cfg_link_reg <= cfg_regs;
    end
  end

  // retrace: 3-stage sync, level irq while enabled; enable bit cleared on reset
  wire vr_rise = vr_sync_reg[1] & vr_sync_reg[2] & ~vr_seen_reg;
  wire irq_on  = vret_end_reg[pcibr_pkg::RETRACE_EN_BIT];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      vr_sync_reg <= 3'h0;
      vr_seen_reg <= 1'b0;
      vret_end_reg <= 8'h00;
      retrace_irq_n_o <= 1'b0;
      retrace_irq_n_oe <= 1'b0;
    end else begin
      vr_sync_reg <= {vr_sync_reg[1:0], vretrace};
      if (vr_sync_reg[1] == vr_sync_reg[2]) vr_seen_reg <= vr_sync_reg[2];
      if (retrace_en_wr) vret_end_reg[pcibr_pkg::RETRACE_EN_BIT] <= retrace_en_val;
      if (vr_rise & irq_on) retrace_irq_n_oe <= 1'b1;
      else if (!irq_on) retrace_irq_n_oe <= 1'b0; // disable releases
    end
  end
endmodule : pcibr_target
`default_nettype wire

// file: pcibr_chk.sv
// Purpose: protocol checks on the link joining the two bridge ends
// Assumes: one data phase per transaction, all in the link clock domain
// Notes:   devsel to trdy spacing follows the two-clock WAIT_CYCLES strobe lead
`timescale 1ns/1ps
`default_nettype none
module pcibr_chk (
  input wire logic        link_clk,
  input wire logic        rst_n,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe_n,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic        trdy_n,
  input wire logic        devsel_n,
  input wire logic        stop_n,
  input wire logic        lock_n,
  input wire logic        idsel,
  input wire logic        par,
  input wire logic        par_m_oe,
  input wire logic        par_t_oe,
  input wire logic        ad_m_oe,
  input wire logic        ad_t_oe,
  input wire logic        req_n
);
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  // parity lags its phase by one clock, so compare against the previous sample
  a_par_even: assert property ((par_m_oe || par_t_oe) |-> par == ^{$past(ad), $past(cbe_n)})
    else $error("parity does not match previous phase");
  a_claim_after_addr: assert property ($fell(devsel_n) |-> $past(frame_n) == 1'b0)
    else $error("devsel without a preceding address phase");
  a_trdy_spacing: assert property ($fell(devsel_n) |-> ##2 (!trdy_n && !stop_n))
    else $error("trdy and stop not two clocks after devsel");
  a_trdy_needs_sel: assert property (!trdy_n |-> !devsel_n)
    else $error("trdy without devsel");
  a_phase_release: assert property ((!trdy_n && !irdy_n) |=> (trdy_n && devsel_n && irdy_n))
    else $error("handshake not released after completion");
  a_frame_single: assert property ($fell(frame_n) |=> (frame_n && !irdy_n))
    else $error("frame not a single address clock");
  a_lock_refused: assert property (($fell(frame_n) && !lock_n) |=> devsel_n [*4])
    else $error("locked cycle claimed");
  a_idsel_cmd_only: assert property (($fell(frame_n) && idsel && cbe_n[3:1] != 3'h5)
    |=> devsel_n [*3])
    else $error("idsel claimed a non-configuration command");
  a_no_contend: assert property (!(ad_m_oe && ad_t_oe))
    else $error("both ends drive address/data");
  a_never_master: assert property (req_n)
    else $error("target requested the bus");
  c_claim: cover property ($fell(devsel_n));
  c_done: cover property (!trdy_n && !irdy_n);
  c_lock: cover property ($fell(frame_n) && !lock_n);
endmodule : pcibr_chk
`default_nettype wire

// file: test_pci_host_aux_bus_bridge.sv
// Purpose: self-checking bench, master end facing target end
// Assumes: one transaction at a time, eight idle link clocks between them
// Notes:   far aux bus shows the inverse byte whenever no read strobe and no rom enable is low
`timescale 1ns/1ps
`default_nettype none
module test_pci_host_aux_bus_bridge;
  typedef struct {logic [3:0] code; logic [31:0] addr; logic [31:0] wd; logic cfg;
    logic [4:0] strb; logic [7:0] byt; logic [31:0] rd; logic ab;} pcibr_row_type;
  localparam logic [23:0] STRAPS = 24'h3ca596;
  logic core_clk, link_clk, rstn, cmd_valid, cmd_cfg_sel, cmd_lock, vretrace, en_wr, en_val;
  logic [3:0]  cmd_code, cmd_be_n, sel, selcap, cap_cbe;
  logic [31:0] cmd_addr, cmd_wdata, rsp_rdata, cap_ad;
  logic        cmd_busy, rsp_valid, rsp_abort, aux_oe, irq_o, irq_oe, fr_q;
  logic        ard_n, awr_n, prd_n, pwr_n, rom_n;
  logic [23:0] cfg_regs;
  logic [7:0]  aux_i, aux_o, rdbyte, wcap;
  logic [4:0]  seen;
  pcibr_row_type lr;
  int err_count, comparisons;
  pcibr_row_type rows [10] = '{
    '{4'h3, 32'h0000_0305, 32'h1122_3344, 1'b0, 5'h08, 8'h33, 32'h0, 1'b0},
    '{4'h2, 32'h0000_030a, 32'h0, 1'b0, 5'h10, 8'h5a, 32'h5a5a_5a5a, 1'b0},
    '{4'h3, 32'h0000_03cf, 32'ha1b2_c3d4, 1'b0, 5'h02, 8'ha1, 32'h0, 1'b0},
    '{4'h2, 32'h0000_03c0, 32'h0, 1'b0, 5'h04, 8'h7e, 32'h7e7e_7e7e, 1'b0},
    '{4'h6, 32'h000c_0010, 32'h0, 1'b0, 5'h01, 8'hc3, 32'hc3c3_c3c3, 1'b0},
    '{4'ha, 32'h0000_0000, 32'h0, 1'b1, 5'h00, 8'h00, {8'h00, STRAPS}, 1'b0},
    '{4'hb, 32'h0000_0004, 32'h0, 1'b1, 5'h00, 8'h00, 32'h0, 1'b0},
    '{4'h2, 32'h0000_0400, 32'h0, 1'b0, 5'h00, 8'h00, 32'h0, 1'b1},
    '{4'h2, 32'h0000_0305, 32'h0, 1'b1, 5'h00, 8'h00, 32'h0, 1'b1},
    '{4'ha, 32'h0000_0000, 32'h0, 1'b0, 5'h00, 8'h00, 32'h0, 1'b1}};
  pcibr_if bus_if (.link_clk(link_clk));
  pcibr_master i_pcibr_master (.bus(bus_if), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be_n(cmd_be_n),
    .cmd_cfg_sel(cmd_cfg_sel), .cmd_lock(cmd_lock), .cmd_busy(cmd_busy),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_abort(rsp_abort));
  pcibr_target i_pcibr_target (.bus(bus_if), .core_clk(core_clk), .rstn(rstn),
    .mem_data_strap_lines(STRAPS), .vretrace(vretrace), .aux_data_bus_i(aux_i),
    .aux_data_bus_o(aux_o), .aux_data_bus_oe(aux_oe), .aux_read_strobe_n(ard_n),
    .aux_write_strobe_n(awr_n), .palette_read_strobe_n(prd_n),
    .palette_write_strobe_n(pwr_n), .rom_output_enable_n(rom_n),
    .aux_register_select(sel), .retrace_irq_n_o(irq_o), .retrace_irq_n_oe(irq_oe),
    .cfg_regs(cfg_regs), .retrace_en_wr(en_wr), .retrace_en_val(en_val));
  pcibr_chk i_pcibr_chk (.link_clk(link_clk), .rst_n(bus_if.rst_n), .ad(bus_if.ad),
    .cbe_n(bus_if.cbe_n), .frame_n(bus_if.frame_n), .irdy_n(bus_if.irdy_n),
    .trdy_n(bus_if.trdy_n), .devsel_n(bus_if.devsel_n), .stop_n(bus_if.stop_n),
    .lock_n(bus_if.lock_n), .idsel(bus_if.idsel), .par(bus_if.par),
    .par_m_oe(bus_if.par_m_oe), .par_t_oe(bus_if.par_t_oe), .ad_m_oe(bus_if.ad_m_oe),
    .ad_t_oe(bus_if.ad_t_oe), .req_n(bus_if.req_n));
  // far aux device: released lines show the inverse so stale data cannot pass
  assign aux_i = (!ard_n || !prd_n || !rom_n) ? rdbyte : ~rdbyte;
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // phase offset keeps the link clock unrelated to the core clock
  initial begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  // wire monitor: address phase, strobes seen, select and write byte
  always @(posedge link_clk) begin
    fr_q <= bus_if.frame_n;
    if (!bus_if.frame_n && fr_q) begin
      cap_ad <= bus_if.ad;
      cap_cbe <= bus_if.cbe_n;
    end
    seen <= seen | {~ard_n, ~awr_n, ~prd_n, ~pwr_n, ~rom_n};
    if (!ard_n || !awr_n || !prd_n || !pwr_n) selcap <= sel;
    if (aux_oe) wcap <= aux_o;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic final_report();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task automatic run(input pcibr_row_type r, input logic lk);
    int n;
    @(negedge link_clk);
    seen = 5'h00;
    {cmd_code, cmd_addr, cmd_wdata, cmd_cfg_sel, cmd_lock, rdbyte} = {r.code, r.addr, r.wd, r.cfg, lk, r.byt};
    cmd_be_n = r.cfg ? 4'h0 : ~(4'h1 << r.addr[1:0]);
    cmd_valid = 1'b1;
    @(negedge link_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    if (n == 40) begin
      err_count++;
      final_report();
    end else begin
      chk(32'(cmd_busy), 32'h1);
      chk(32'(rsp_abort), 32'(r.ab));
      chk(32'(seen), 32'(r.strb));
      chk(cap_ad, r.addr);
      chk(32'(cap_cbe), 32'(r.code));
      if (!r.code[0] && !r.ab) chk(rsp_rdata, r.rd);
      if (r.strb[3] || r.strb[1]) chk(32'(wcap), 32'(r.byt));
      if (r.strb[4:1] != 4'h0) chk(32'(selcap), 32'(r.addr[3:0]));
      repeat (8) @(negedge link_clk);
      chk(32'(cmd_busy), 32'h0);
    end
  endtask : run
  initial begin
    {rstn, cmd_valid, cmd_cfg_sel, cmd_lock, vretrace, en_wr, en_val} = 7'h00;
    {cmd_code, cmd_be_n, cmd_addr, cmd_wdata, rdbyte} = '0;
    {err_count, comparisons, seen, fr_q} = '0;
    repeat (6) @(negedge core_clk);
    chk(32'({ard_n, awr_n, prd_n, pwr_n, rom_n, aux_oe, irq_oe}), 32'h7c);
    chk(32'({bus_if.trdy_n, bus_if.devsel_n, bus_if.ad_t_oe, cfg_regs}), 32'h600_0000);
    rstn = 1'b1;
    repeat (4) @(negedge link_clk);
    chk(32'(cfg_regs), 32'(STRAPS));
    foreach (rows[i]) run(rows[i], 1'b0);
    lr = rows[1];
    lr.strb = 5'h00;
    lr.ab = 1'b1;
    run(lr, 1'b1);
    // retrace: masked, then enabled, then masked again
    @(negedge core_clk);
    vretrace = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(32'(irq_oe), 32'h0);
    // an edge seen while masked must not fire later: drop and raise again
    {en_wr, en_val, vretrace} = 3'h6;
    @(negedge core_clk);
    en_wr = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(32'(irq_oe), 32'h0);
    vretrace = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(32'({irq_oe, irq_o}), 32'h2);
    {en_wr, en_val} = 2'h2;
    @(negedge core_clk);
    en_wr = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(32'(irq_oe), 32'h0);
    // second reset in mid-run, then a transfer must still work
    rstn = 1'b0;
    repeat (3) @(negedge link_clk);
    chk(32'({bus_if.trdy_n, bus_if.stop_n, bus_if.ad_t_oe, aux_oe}), 32'hc);
    @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge link_clk);
    run(rows[2], 1'b0);
    final_report();
  end
endmodule : test_pci_host_aux_bus_bridge
`default_nettype wire
